/* File: test/gcd_host_model.sv */
// gcd_host_model.sv: the host controller facing the column decoder
// assumes a registered one-cycle ack from the decoder's bus slave
`include "gcd_regs.svh"
`default_nettype none

module gcd_host_model
(
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [7:0]  adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] dat_o,
  output logic             hang_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ******************************************
  // bus cycles
  // ******************************************
  // idle bus at time zero
  initial
  begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h1;
    dat_o = 32'h00000000;
    hang_o = 1'b0;
  end

  // one classic cycle, held until ack is sampled high
  task automatic acc(input logic we, input logic [7:0] adr,
                     input logic [7:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= we;
    adr_o <= adr;
    dat_o <= {24'h000000, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_i !== 1'b1 && n < 20);
    // judge by the answer itself, so a late ack is not a hang
    if (ack_i !== 1'b1)
      hang_o <= 1'b1;
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // released lines flip so stale values never pass for live ones
    we_o <= ~we;
    adr_o <= ~adr;
    dat_o <= ~dat_o;
  endtask

  // wait for busy and reset flags to clear before any instruction
  task automatic poll();
    logic [31:0] s;
    int n;
    n = 0;
    do
    begin
      acc(1'b0, `GCD_CMD_OFS, 8'h00, s);
      n++;
    end
    while ((s[`GCD_BUSY_BIT] | s[`GCD_RESET_BIT]) !== 1'b0 && n < 50);
    if ((s[`GCD_BUSY_BIT] | s[`GCD_RESET_BIT]) !== 1'b0)
      hang_o <= 1'b1;
  endtask

  // polled command write with byte lane 0 off; lanes restored after
  task automatic nsel(input logic [7:0] d);
    logic [31:0] q;
    poll();
    sel_o <= 4'hE;
    acc(1'b1, `GCD_CMD_OFS, d, q);
    sel_o <= 4'h1;
  endtask

  // polled instruction, data write and data read
  task automatic cmd(input logic [7:0] d);
    logic [31:0] q;
    poll();
    acc(1'b1, `GCD_CMD_OFS, d, q);
  endtask

  task automatic dwr(input logic [7:0] d);
    logic [31:0] q;
    poll();
    acc(1'b1, `GCD_DATA_OFS, d, q);
  endtask

  // first read after an address change is a dummy
  task automatic drd(output logic [31:0] q);
    poll();
    acc(1'b0, `GCD_DATA_OFS, 8'h00, q);
  endtask
endmodule

`default_nettype wire

/* File: test/graphic_lcd_column_command_decoder_test.sv */
// graphic_lcd_column_command_decoder_test.sv: self-checking bench
// assumes the decoder's registered status, memory and scan outputs
`include "gcd_regs.svh"
`default_nettype none

module graphic_lcd_column_command_decoder_test;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_i;
  logic        rst_i;
  logic        cyc, stb, we, ack, hang, dot, on;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  logic        init_n;
  logic [5:0]  row;
  logic [5:0]  col;
  logic [5:0]  start;
  int          fail_count = 0;
  int          compares = 0;

  // ******************************************
  // clock, host and decoder
  // ******************************************
  always #5 clk_i = ~clk_i;

  gcd_host_model h (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat),
    .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
    .dat_o(wdat), .hang_o(hang));

  // long busy so an unpolled access surely lands inside it
  gcd_decoder #(.BUSY_CYCLES(12), .PANEL_ROWS(64)) dut (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .init_pin_n_i(init_n), .scan_row_i(row),
    .scan_col_i(col), .seg_dot_o(dot), .display_on_o(on),
    .start_line_o(start));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // scan one dot; the output is registered, so settle two edges
  task automatic scan(input logic [5:0] r, input logic [5:0] c,
                      input logic e);
    @(posedge clk_i);
    row <= r;
    col <= c;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk({31'h0, dot}, {31'h0, e});
  endtask

  // a stuck handshake ends the run
  always @(posedge hang)
  begin
    fail_count++;
    end_sim();
  end

  // ******************************************
  // scenarios
  // ******************************************
  initial
  begin
    // time-zero levels; every one of them is driven again later
    clk_i = 1'b0;
    rst_i = 1'b1;
    init_n = 1'b1;
    row = 6'h00;
    col = 6'h00;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    h.acc(1'b0, `GCD_CMD_OFS, 8'h00, q);
    chk(q, 32'h20);
    chk({26'h0, start}, 32'h0);
    h.cmd(8'h3F);
    chk({31'h0, on}, 32'h1);
    h.acc(1'b0, `GCD_CMD_OFS, 8'h00, q);
    chk(q, 32'h80);
    h.acc(1'b1, `GCD_CMD_OFS, 8'hC7, q);
    chk({26'h0, start}, 32'h0);
    h.cmd(8'hC5);
    chk({26'h0, start}, 32'h5);
    h.cmd(8'h00);
    h.cmd(8'h80);
    h.acc(1'b0, `GCD_CMD_OFS, 8'h00, q);
    chk(q, 32'h0);
    chk({26'h0, start}, 32'h5);
    // page 3 from column 62 wraps onto column 0
    h.cmd(8'hBB);
    h.cmd(8'h7E);
    h.dwr(8'hA5);
    h.dwr(8'h5A);
    h.dwr(8'hC3);
    // fill the byte the last read latches, so no unknown is latched
    h.dwr(8'h3C);
    h.cmd(8'hBA);
    h.cmd(8'h40);
    h.dwr(8'h11);
    h.dwr(8'h22);
    h.cmd(8'hBB);
    h.cmd(8'h7E);
    h.drd(q);
    h.drd(q);
    chk(q, 32'hA5);
    h.drd(q);
    chk(q, 32'h5A);
    h.drd(q);
    chk(q, 32'hC3);
    // write without byte lane 0 must not reach the decoder
    h.nsel(8'h3E);
    chk({31'h0, on}, 32'h1);
    // blank then show again; memory must survive
    h.cmd(8'h3E);
    chk({31'h0, on}, 32'h0);
    scan(6'd19, 6'd62, 1'b0);
    h.poll();
    h.acc(1'b0, `GCD_CMD_OFS, 8'h00, q);
    chk(q, 32'h20);
    h.cmd(8'h3F);
    h.cmd(8'hBA);
    h.cmd(8'h40);
    h.drd(q);
    h.drd(q);
    chk(q, 32'h11);
    chk({26'h0, start}, 32'h5);
    // start line 5 puts memory line 24 on row 19
    scan(6'd19, 6'd62, 1'b1);
    scan(6'd20, 6'd62, 1'b0);
    scan(6'd20, 6'd63, 1'b1);
    h.acc(1'b0, 8'h08, 8'h00, q);
    chk(q, 32'h0);
    // init pin low: display off, start zero, status only
    @(posedge clk_i);
    init_n <= 1'b0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk({31'h0, on}, 32'h0);
    chk({26'h0, start}, 32'h0);
    h.acc(1'b0, `GCD_CMD_OFS, 8'h00, q);
    chk(q, 32'h30);
    h.acc(1'b1, `GCD_CMD_OFS, 8'h3F, q);
    chk({31'h0, on}, 32'h0);
    @(posedge clk_i);
    init_n <= 1'b1;
    h.poll();
    h.acc(1'b0, `GCD_CMD_OFS, 8'h00, q);
    chk(q, 32'h20);
    end_sim();
  end
endmodule

`default_nettype wire

/* File: verilog/gcd_decoder.sv */
// gcd_decoder.sv: command decoder and frame memory of a 64-column
// segment driver, reached over a classic Wishbone slave
// assumes one clock, synchronous inputs, scan row/column from outside
`include "gcd_regs.svh"
`default_nettype none

module gcd_decoder
  import gcd_pkg::*;
#(
  parameter int BUSY_CYCLES = `GCD_BUSY_CYCLES,
  parameter int PANEL_ROWS  = 64
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        init_pin_n_i,
  input  wire logic [5:0]  scan_row_i,
  input  wire logic [5:0]  scan_col_i,
  output logic             seg_dot_o,
  output logic             display_on_o,
  output logic      [5:0]  start_line_o
);

  localparam int BW = $clog2(BUSY_CYCLES + 1);

  // ********************************************
  // state
  // ********************************************
  gcd_bus_state_t state;
  gcd_bus_state_t next_state;
  logic [31:0]    rdata;
  logic [31:0]    next_rdata;
  gcd_col_t       col;
  gcd_col_t       next_col;
  gcd_page_t      page;
  gcd_page_t      next_page;
  gcd_line_t      start;
  gcd_line_t      next_start;
  logic           disp_on;
  logic           next_disp_on;
  logic           reset_flag;
  logic           next_reset_flag;
  logic [BW-1:0]  busy_cnt;
  logic [BW-1:0]  next_busy_cnt;
  logic [7:0]     out_reg;
  logic [7:0]     next_out_reg;
  logic           seg_dot;
  logic           next_seg_dot;
  logic [7:0]     frame_memory [0:511];

  // ********************************************
  // request decode
  // ********************************************
  logic       req;
  logic       register_select;
  logic       hit_cmd;
  logic       busy;
  logic       ready;
  logic [7:0] wbyte;
  logic       cmd_wr;
  logic       data_wr;
  logic       data_rd;
  logic       stat_rd;
  logic       is_onoff;
  logic       is_col;
  logic       is_page;
  logic       is_start;
  logic [7:0] status;
  logic [8:0] mem_addr;
  logic [7:0] cur_byte;
  gcd_line_t  scan_line;
  logic [7:0] scan_byte;

  // one request per idle cycle; ack state blocks re-taking
  assign req             = wb_cyc_i & wb_stb_i & (state == gcd_idle);
  assign register_select = (wb_adr_i == `GCD_DATA_OFS);
  assign hit_cmd         = (wb_adr_i == `GCD_CMD_OFS);
  assign busy            = (busy_cnt != '0);
  // status reads bypass this; everything else is acked at once but dropped unless ready
  assign ready   = !busy && !reset_flag && init_pin_n_i;
  assign wbyte   = wb_dat_i[7:0];
  assign cmd_wr  = req & hit_cmd & wb_we_i & wb_sel_i[0] & ready;
  assign data_wr = req & register_select & wb_we_i & wb_sel_i[0] & ready;
  assign data_rd = req & register_select & !wb_we_i & ready;
  assign stat_rd = req & hit_cmd & !wb_we_i;

  // patterns are disjoint, so no priority among them
  assign is_onoff = (wbyte & `GCD_ONOFF_MASK) == `GCD_ONOFF_VAL;
  assign is_col   = (wbyte & `GCD_COL_MASK) == `GCD_COL_VAL;
  assign is_page  = (wbyte & `GCD_PAGE_MASK) == `GCD_PAGE_VAL;
  assign is_start = (wbyte & `GCD_START_MASK) == `GCD_START_VAL;

  // spare status bits stay zero
  always_comb
  begin
    status                 = 8'h00;
    status[`GCD_BUSY_BIT]  = busy;
    status[`GCD_ONOFF_BIT] = !disp_on;
    status[`GCD_RESET_BIT] = reset_flag;
  end

  // host access always lands in the loaded page
  assign mem_addr = {page, col};
  assign cur_byte = frame_memory[mem_addr];

  // scan path: wraps through the 64 memory lines
  assign scan_line = gcd_line_t'(start + scan_row_i);
  assign scan_byte = frame_memory[{scan_line[5:3], scan_col_i}];

  // ********************************************
  // next-state logic
  // ********************************************
  always_comb
  begin
    next_state      = state;
    next_rdata      = rdata;
    next_col        = col;
    next_page       = page;
    next_start      = start;
    next_disp_on    = disp_on;
    next_out_reg    = out_reg;
    next_reset_flag = !init_pin_n_i;
    next_busy_cnt   = busy ? BW'(busy_cnt - 1'b1) : busy_cnt;
    next_seg_dot    = disp_on && (int'(scan_row_i) < PANEL_ROWS)
                      && scan_byte[scan_line[2:0]];
    unique case (state)
      gcd_idle:
      begin
        if (req)
        begin
          next_state = gcd_ack;
          next_rdata = 32'h0000_0000;
        end
        if (stat_rd)
        begin
          next_rdata = {24'h00_0000, status};
        end
        if (req && register_select && !wb_we_i)
        begin
          // ignored reads still answer with the held byte
          next_rdata = {24'h00_0000, out_reg};
        end
        if (data_rd)
        begin
          next_out_reg  = cur_byte;
          next_col      = gcd_col_t'(col + 6'h01);
          next_busy_cnt = BW'(BUSY_CYCLES);
        end
        if (data_wr)
        begin
          next_col      = gcd_col_t'(col + 6'h01);
          next_busy_cnt = BW'(BUSY_CYCLES);
        end
        // only the addressed field changes; others stay
        if (cmd_wr && (is_onoff || is_col || is_page || is_start))
        begin
          next_busy_cnt = BW'(BUSY_CYCLES);
          if (is_onoff)
          begin
            next_disp_on = wbyte[0];
          end
          if (is_col)
          begin
            next_col = wbyte[5:0];
          end
          if (is_page)
          begin
            next_page = wbyte[2:0];
          end
          if (is_start)
          begin
            next_start = wbyte[5:0];
          end
        end
      end
      gcd_ack:
      begin
        next_state = gcd_idle;
      end
    endcase
    // init pin overrides any command of the same cycle
    if (!init_pin_n_i)
    begin
      next_disp_on = 1'b0;
      next_start   = `GCD_START_RST;
    end
  end

  // ********************************************
  // registers
  // ********************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state      <= gcd_idle;
      rdata      <= 32'h0000_0000;
      col        <= `GCD_COL_RST;
      page       <= `GCD_PAGE_RST;
      start      <= `GCD_START_RST;
      disp_on    <= 1'b0;
      reset_flag <= 1'b1;
      busy_cnt   <= '0;
      out_reg    <= 8'h00;
      seg_dot    <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      rdata      <= next_rdata;
      col        <= next_col;
      page       <= next_page;
      start      <= next_start;
      disp_on    <= next_disp_on;
      reset_flag <= next_reset_flag;
      busy_cnt   <= next_busy_cnt;
      out_reg    <= next_out_reg;
      seg_dot    <= next_seg_dot;
    end
  end

  // memory has no reset; contents survive on/off
  always_ff @(posedge clk_i)
  begin
    if (data_wr)
    begin
      frame_memory[mem_addr] <= wbyte;
    end
  end

  assign wb_dat_o     = rdata;
  assign wb_ack_o     = state[1]; // one-hot ack bit, straight from flop
  assign seg_dot_o    = seg_dot;
  assign display_on_o = disp_on;
  assign start_line_o = start;

  // ********************************************
  // assertions
  // ********************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_take_status;
    stat_rd;
  endsequence

  sequence s_answer_status(logic [7:0] st);
    wb_ack_o && (wb_dat_o[7:0] == st);
  endsequence

  property p_onoff;
    cmd_wr && is_onoff |=> display_on_o == $past(wbyte[0]);
  endproperty
  a_onoff: assert property (p_onoff)
    else $error("on/off command not applied");

  property p_onoff_keep;
    cmd_wr && is_onoff |=> $stable(col) && $stable(page)
      && $stable(start_line_o);
  endproperty
  a_onoff_keep: assert property (p_onoff_keep)
    else $error("on/off command disturbed pointers");

  property p_col_set;
    cmd_wr && is_col |=> col == $past(wbyte[5:0]);
  endproperty
  a_col_set: assert property (p_col_set)
    else $error("column pointer not loaded");

  property p_wr_inc;
    data_wr |=> col == gcd_col_t'($past(col) + 6'h01)
      && $stable(page);
  endproperty
  a_wr_inc: assert property (p_wr_inc)
    else $error("column did not advance on write");

  property p_rd_inc;
    data_rd |=> col == gcd_col_t'($past(col) + 6'h01)
      && out_reg == $past(cur_byte);
  endproperty
  a_rd_inc: assert property (p_rd_inc)
    else $error("column or latch wrong after read");

  property p_page_set;
    cmd_wr && is_page |=> page == $past(wbyte[2:0]);
  endproperty
  a_page_set: assert property (p_page_set)
    else $error("page not loaded");

  property p_start_set;
    cmd_wr && is_start && init_pin_n_i
      |=> start_line_o == $past(wbyte[5:0]);
  endproperty
  a_start_set: assert property (p_start_set)
    else $error("start line not loaded");

  property p_busy_ignore;
    req && wb_we_i && busy |=> $stable(col) && $stable(page)
      && $stable(start_line_o) && $stable(display_on_o);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore)
    else $error("write taken while busy");

  property p_status_answer;
    logic [7:0] st;
    (s_take_status, st = status) |=> s_answer_status(st) ##1 !wb_ack_o;
  endproperty
  a_status_answer: assert property (p_status_answer)
    else $error("status answer wrong");

  property p_init_flag;
    !init_pin_n_i |=> status[`GCD_RESET_BIT] && !display_on_o
      && start_line_o == 6'h00;
  endproperty
  a_init_flag: assert property (p_init_flag)
    else $error("init pin not honoured");

  property p_unknown;
    cmd_wr && !(is_onoff || is_col || is_page || is_start)
      |=> $stable(col) && $stable(page) && $stable(start_line_o)
      && $stable(display_on_o) && !busy;
  endproperty
  a_unknown: assert property (p_unknown)
    else $error("unknown command changed state");

endmodule

`default_nettype wire

/* File: verilog/gcd_pkg.sv */
// gcd_pkg.sv: types shared by the column decoder
// assumes nothing beyond a SystemVerilog elaborator
`default_nettype none

package gcd_pkg;

  // bus answer state, one-hot
  typedef enum logic [1:0]
  {
    gcd_idle = 2'h1,
    gcd_ack  = 2'h2
  } gcd_bus_state_t;

  typedef logic [5:0] gcd_col_t;
  typedef logic [2:0] gcd_page_t;
  typedef logic [5:0] gcd_line_t;

endpackage

`default_nettype wire

/* File: verilog/gcd_regs.svh */
// gcd_regs.svh: offsets, command patterns, reset values and counts
// of the column decoder; assumes a single 100 MHz clock domain
// Function
// - on/off command sets display flip-flop
// - column command loads six-bit pointer
// - data write advances column by one
// - data read advances column by one
// - page command loads three-bit page
// - data accesses use current page
// - start command loads start line
// - panel rows shown from start line
// - busy reported, instructions ignored while busy
// - ready device accepts any instruction
// - initialisation flag set, only status reads
// - init flag clears; spare status bits zero
// - data write stores byte at page/column
// - data read drives memory byte
// - status on command slot, memory on data
// - memory read returns previously latched byte
// - status on/off bit high when blanked
// - init pin blanks display, zeroes start
`ifndef GCD_REGS_SVH
`define GCD_REGS_SVH

// ********************************************
// register word offsets on the bus
// ********************************************
`define GCD_CMD_OFS     8'h00
`define GCD_DATA_OFS    8'h04

// ********************************************
// command masks and patterns
// ********************************************
`define GCD_ONOFF_MASK  8'hFE
`define GCD_ONOFF_VAL   8'h3E
`define GCD_COL_MASK    8'hC0
`define GCD_COL_VAL     8'h40
`define GCD_PAGE_MASK   8'hF8
`define GCD_PAGE_VAL    8'hB8
`define GCD_START_MASK  8'hC0
`define GCD_START_VAL   8'hC0

// ********************************************
// status bit positions, reset values, timing
// ********************************************
`define GCD_BUSY_BIT    7
`define GCD_ONOFF_BIT   5
`define GCD_RESET_BIT   4
`define GCD_COL_RST     6'h00
`define GCD_PAGE_RST    3'h0
`define GCD_START_RST   6'h00
`define GCD_BUSY_CYCLES 4

`endif
